// ===== irq_prio_pkg.sv
package irq_prio_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int unsigned NUM_SRC = 15;
  localparam int unsigned IDX_W   = 4;
  localparam int unsigned FLAG_W  = 2;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] BASE_PRIO_ADDR = 8'hb8;
  localparam logic [7:0] EXT_MASK_ADDR  = 8'he6;
  localparam logic [7:0] EXT_PRIO_ADDR  = 8'hf6;
  localparam logic [7:0] STATUS_ADDR    = 8'hf7;

  // ----------------------------------------------------------------
  // Reset values and bit layouts
  // ----------------------------------------------------------------
  localparam logic [7:0] BASE_PRIO_RST  = 8'h80;
  localparam logic [7:0] EXT_MASK_RST   = 8'h00;
  localparam logic [7:0] EXT_PRIO_RST   = 8'h00;
  // Base top bit is not stored and always reads one
  localparam logic [7:0] BASE_PRIO_WMSK = 8'h7f;
  localparam logic [7:0] BASE_PRIO_ONES = 8'h80;
  // Extended bit 1 is reserved: not stored, reads zero
  localparam logic [7:0] EXT_WMSK       = 8'hfd;
  localparam int unsigned EXT_RSVD_BIT  = 1;
  localparam logic [7:0] RDATA_IDLE     = 8'h00;

  // Status register fields
  localparam int unsigned ST_HOLD_BIT = 7;
  localparam int unsigned ST_HI_BIT   = 6;
  localparam int unsigned ST_LO_BIT   = 5;
  localparam int unsigned ST_REQ_BIT  = 4;

  // ----------------------------------------------------------------
  // Source order numbers (lower number wins within a level)
  // ----------------------------------------------------------------
  localparam int unsigned SRC_EXT0  = 0;
  localparam int unsigned SRC_TMR0  = 1;
  localparam int unsigned SRC_EXT1  = 2;
  localparam int unsigned SRC_TMR1  = 3;
  localparam int unsigned SRC_UART  = 4;
  localparam int unsigned SRC_TMR2  = 5;
  localparam int unsigned SRC_SPI   = 6;
  localparam int unsigned SRC_SMB   = 7;
  localparam int unsigned SRC_RSVD  = 8;
  localparam int unsigned SRC_ADCW  = 9;
  localparam int unsigned SRC_ADCD  = 10;
  localparam int unsigned SRC_PCA   = 11;
  localparam int unsigned SRC_CMP0  = 12;
  localparam int unsigned SRC_CMP1  = 13;
  localparam int unsigned SRC_TMR3  = 14;

  // Extended register bit positions
  localparam int unsigned EXT_TMR3_BIT = 7;
  localparam int unsigned EXT_CMP1_BIT = 6;
  localparam int unsigned EXT_CMP0_BIT = 5;
  localparam int unsigned EXT_PCA_BIT  = 4;
  localparam int unsigned EXT_ADCD_BIT = 3;
  localparam int unsigned EXT_ADCW_BIT = 2;
  localparam int unsigned EXT_SMB_BIT  = 0;

  // ----------------------------------------------------------------
  // Service level tracking
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    SVC_IDLE    = 4'b0001,
    SVC_LOW     = 4'b0010,
    SVC_HIGH    = 4'b0100,
    SVC_HI_O_LO = 4'b1000
  } svc_state_type;

endpackage : irq_prio_pkg

// ===== irq_source_gate.sv
`timescale 1ns/1ps
`default_nettype none
module irq_source_gate #(
  parameter int unsigned FW = 2
) (
  // Pending flags of one source
  input  wire logic [FW-1:0] flags,
  // Configuration
  input  wire logic          mask,
  input  wire logic          prio,
  input  wire logic          global_en,
  // Qualified request by level
  output logic               req_hi,
  output logic               req_lo
);

  // Any flag raises the source once the mask and global enable allow
  logic taken;
  assign taken  = (|flags) & mask & global_en;
  assign req_hi = taken & prio;
  assign req_lo = taken & ~prio;

endmodule : irq_source_gate
`default_nettype wire

// ===== fixed_order_pick.sv
`timescale 1ns/1ps
`default_nettype none
module fixed_order_pick #(
  parameter int unsigned N  = 15,
  parameter int unsigned IW = 4
) (
  // Requests of one level
  input  wire logic [N-1:0]  req,
  // Winner
  output logic               any,
  output logic [IW-1:0]      idx
);

  // Scan downward so the lowest order number is the last to land
  always_comb begin
    idx = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i]) begin
        idx = IW'(i);
      end
    end
  end

  assign any = |req;

endmodule : fixed_order_pick
`default_nettype wire

// ===== interrupt_priority_enable.sv
// Operation
// - Base priority top bit reads one, writes ignored.
// - Base bit 6 sets SPI level, one is high.
// - Base bit 5 sets timer 2 level.
// - Base bit 4 sets serial port level.
// - Base bit 3 sets timer 1 level.
// - Base bit 2 sets external interrupt 1 level.
// - Base bit 1 sets timer 0 level.
// - Base bit 0 sets external interrupt 0 level.
// - Extended bit 7 passes timer 3 low or high overflow.
// - Extended bit 6 passes comparator 1 rise or fall flag.
// - Extended bit 5 passes comparator 0 rise or fall flag.
// - Extended bit 4 passes all counter array requests.
// - Extended bit 3 passes ADC conversion complete.
// - Extended bit 2 passes ADC window compare.
// - Extended bit 1 reserved: reads zero, software writes zero.
// - Extended bit 0 passes all SMBus requests.
// - Extended priority bits pick low or high per source.
// - Global enable off blocks every source regardless of masks.
// - Pending requests sampled and decoded every clock with ce high.
// - Equal or lower level waits for return plus one instruction.
`timescale 1ns/1ps
`default_nettype none
module interrupt_priority_enable (
  // Clock, reset, enable
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       ce,
  // Register port
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata_r,
  // Enables held in the base enable register elsewhere
  input  wire logic       global_irq_enable,
  input  wire logic [6:0] base_irq_enable,
  // Pending flags from peripherals
  input  wire logic       ext_irq0_flag,
  input  wire logic       timer0_flag,
  input  wire logic       ext_irq1_flag,
  input  wire logic       timer1_flag,
  input  wire logic [1:0] serial_port_flags,
  input  wire logic [1:0] timer2_flags,
  input  wire logic       spi_flag,
  input  wire logic       smbus_flag,
  input  wire logic       adc_window_flag,
  input  wire logic       adc_done_flag,
  input  wire logic       counter_array_flag,
  input  wire logic       comparator0_rise_flag,
  input  wire logic       comparator0_fall_flag,
  input  wire logic       comparator1_rise_flag,
  input  wire logic       comparator1_fall_flag,
  input  wire logic       timer3_low_overflow_flag,
  input  wire logic       timer3_high_overflow_flag,
  // CPU handshake
  input  wire logic       irq_ack,
  input  wire logic       irq_return,
  input  wire logic       instr_done,
  output logic            irq_req_r,
  output logic      [3:0] irq_index_r,
  output logic            irq_level_r,
  output logic            hi_active_r,
  output logic            lo_active_r
);

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  logic [7:0] base_prio_r;
  logic [7:0] ext_mask_r;
  logic [7:0] ext_prio_r;
  logic       hold_r;

  irq_prio_pkg::svc_state_type svc_r;
  irq_prio_pkg::svc_state_type svc_nxt;

  // Write decode, top base bit and reserved bit are never stored
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      base_prio_r <= irq_prio_pkg::BASE_PRIO_RST;
      ext_mask_r  <= irq_prio_pkg::EXT_MASK_RST;
      ext_prio_r  <= irq_prio_pkg::EXT_PRIO_RST;
    end else if (ce && wr) begin
      if (addr == irq_prio_pkg::BASE_PRIO_ADDR) begin
        base_prio_r <= (wdata & irq_prio_pkg::BASE_PRIO_WMSK)
                       | irq_prio_pkg::BASE_PRIO_ONES;
      end
      if (addr == irq_prio_pkg::EXT_MASK_ADDR) begin
        ext_mask_r <= wdata & irq_prio_pkg::EXT_WMSK;
      end
      if (addr == irq_prio_pkg::EXT_PRIO_ADDR) begin
        ext_prio_r <= wdata & irq_prio_pkg::EXT_WMSK;
      end
    end
  end

  // ----------------------------------------------------------------
  // Source assembly
  // ----------------------------------------------------------------
  logic [irq_prio_pkg::FLAG_W-1:0] flags  [irq_prio_pkg::NUM_SRC];
  logic [irq_prio_pkg::NUM_SRC-1:0] masks;
  logic [irq_prio_pkg::NUM_SRC-1:0] prios;
  logic [irq_prio_pkg::NUM_SRC-1:0] hi_vec;
  logic [irq_prio_pkg::NUM_SRC-1:0] lo_vec;

  // Paired flags are OR-ed inside the gate; single flags pad with zero
  always_comb begin
    flags[irq_prio_pkg::SRC_EXT0] = {1'b0, ext_irq0_flag};
    flags[irq_prio_pkg::SRC_TMR0] = {1'b0, timer0_flag};
    flags[irq_prio_pkg::SRC_EXT1] = {1'b0, ext_irq1_flag};
    flags[irq_prio_pkg::SRC_TMR1] = {1'b0, timer1_flag};
    flags[irq_prio_pkg::SRC_UART] = serial_port_flags;
    flags[irq_prio_pkg::SRC_TMR2] = timer2_flags;
    flags[irq_prio_pkg::SRC_SPI]  = {1'b0, spi_flag};
    flags[irq_prio_pkg::SRC_SMB]  = {1'b0, smbus_flag};
    flags[irq_prio_pkg::SRC_RSVD] = 2'h0;
    flags[irq_prio_pkg::SRC_ADCW] = {1'b0, adc_window_flag};
    flags[irq_prio_pkg::SRC_ADCD] = {1'b0, adc_done_flag};
    flags[irq_prio_pkg::SRC_PCA]  = {1'b0, counter_array_flag};
    flags[irq_prio_pkg::SRC_CMP0] = {comparator0_rise_flag,
                                     comparator0_fall_flag};
    flags[irq_prio_pkg::SRC_CMP1] = {comparator1_rise_flag,
                                     comparator1_fall_flag};
    flags[irq_prio_pkg::SRC_TMR3] = {timer3_high_overflow_flag,
                                     timer3_low_overflow_flag};
  end

  // Classic sources take mask and level straight from base bits 6..0,
  // extended sources map to their register bits; one process drives all
  always_comb begin
    masks[irq_prio_pkg::SRC_SPI:0] = base_irq_enable;
    prios[irq_prio_pkg::SRC_SPI:0] = base_prio_r[6:0];
    masks[irq_prio_pkg::SRC_SMB]  = ext_mask_r[irq_prio_pkg::EXT_SMB_BIT];
    masks[irq_prio_pkg::SRC_RSVD] = 1'b0;
    masks[irq_prio_pkg::SRC_ADCW] = ext_mask_r[irq_prio_pkg::EXT_ADCW_BIT];
    masks[irq_prio_pkg::SRC_ADCD] = ext_mask_r[irq_prio_pkg::EXT_ADCD_BIT];
    masks[irq_prio_pkg::SRC_PCA]  = ext_mask_r[irq_prio_pkg::EXT_PCA_BIT];
    masks[irq_prio_pkg::SRC_CMP0] = ext_mask_r[irq_prio_pkg::EXT_CMP0_BIT];
    masks[irq_prio_pkg::SRC_CMP1] = ext_mask_r[irq_prio_pkg::EXT_CMP1_BIT];
    masks[irq_prio_pkg::SRC_TMR3] = ext_mask_r[irq_prio_pkg::EXT_TMR3_BIT];
    prios[irq_prio_pkg::SRC_SMB]  = ext_prio_r[irq_prio_pkg::EXT_SMB_BIT];
    prios[irq_prio_pkg::SRC_RSVD] = 1'b0;
    prios[irq_prio_pkg::SRC_ADCW] = ext_prio_r[irq_prio_pkg::EXT_ADCW_BIT];
    prios[irq_prio_pkg::SRC_ADCD] = ext_prio_r[irq_prio_pkg::EXT_ADCD_BIT];
    prios[irq_prio_pkg::SRC_PCA]  = ext_prio_r[irq_prio_pkg::EXT_PCA_BIT];
    prios[irq_prio_pkg::SRC_CMP0] = ext_prio_r[irq_prio_pkg::EXT_CMP0_BIT];
    prios[irq_prio_pkg::SRC_CMP1] = ext_prio_r[irq_prio_pkg::EXT_CMP1_BIT];
    prios[irq_prio_pkg::SRC_TMR3] = ext_prio_r[irq_prio_pkg::EXT_TMR3_BIT];
  end

  // One gate per source, global enable feeds every one
  // global override
  for (genvar g = 0; g < irq_prio_pkg::NUM_SRC; g++) begin : gen_gate
    irq_source_gate #(
      .FW        (irq_prio_pkg::FLAG_W)
    ) u_gate (
      .flags     (flags[g]),
      .mask      (masks[g]),
      .prio      (prios[g]),
      .global_en (global_irq_enable),
      .req_hi    (hi_vec[g]),
      .req_lo    (lo_vec[g])
    );
  end

  // ----------------------------------------------------------------
  // Fixed order selection per level
  // ----------------------------------------------------------------
  logic                          hi_any;
  logic                          lo_any;
  logic [irq_prio_pkg::IDX_W-1:0] hi_idx;
  logic [irq_prio_pkg::IDX_W-1:0] lo_idx;

  fixed_order_pick #(
    .N   (irq_prio_pkg::NUM_SRC),
    .IW  (irq_prio_pkg::IDX_W)
  ) u_pick_hi (
    .req (hi_vec),
    .any (hi_any),
    .idx (hi_idx)
  );

  fixed_order_pick #(
    .N   (irq_prio_pkg::NUM_SRC),
    .IW  (irq_prio_pkg::IDX_W)
  ) u_pick_lo (
    .req (lo_vec),
    .any (lo_any),
    .idx (lo_idx)
  );

  // ----------------------------------------------------------------
  // Service tracking
  // ----------------------------------------------------------------
  // Return leaves the innermost level; ack enters the presented one
  always_comb begin
    svc_nxt = svc_r;
    if (irq_return) begin
      case (svc_r)
        irq_prio_pkg::SVC_HI_O_LO: svc_nxt = irq_prio_pkg::SVC_LOW;
        irq_prio_pkg::SVC_HIGH:    svc_nxt = irq_prio_pkg::SVC_IDLE;
        irq_prio_pkg::SVC_LOW:     svc_nxt = irq_prio_pkg::SVC_IDLE;
        default:                   svc_nxt = svc_r;
      endcase
    end else if (irq_ack && irq_req_r) begin
      case (svc_r)
        irq_prio_pkg::SVC_IDLE: begin
          svc_nxt = irq_level_r ? irq_prio_pkg::SVC_HIGH
                                : irq_prio_pkg::SVC_LOW;
        end
        irq_prio_pkg::SVC_LOW: begin
          if (irq_level_r) begin
            svc_nxt = irq_prio_pkg::SVC_HI_O_LO;
          end
        end
        default: svc_nxt = svc_r;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      svc_r <= irq_prio_pkg::SVC_IDLE;
    end else if (ce) begin
      svc_r <= svc_nxt;
    end
  end

  // One instruction must complete after a return before a new call
  // hold after return
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hold_r <= 1'b0;
    end else if (ce) begin
      if (irq_return) begin
        hold_r <= 1'b1;
      end else if (instr_done) begin
        hold_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Request decision, recomputed every cycle with ce high
  // ----------------------------------------------------------------
  logic in_hi;
  logic in_lo;
  logic hi_ok;
  logic lo_ok;

  assign in_hi = (svc_r == irq_prio_pkg::SVC_HIGH)
               | (svc_r == irq_prio_pkg::SVC_HI_O_LO);
  assign in_lo = (svc_r == irq_prio_pkg::SVC_LOW);

  assign hi_ok = hi_any & ~in_hi & ~hold_r;
  assign lo_ok = lo_any & ~in_hi & ~in_lo & ~hold_r;

  // Ack drops the request at once so it is not taken twice
  // decode each cycle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irq_req_r   <= 1'b0;
      irq_index_r <= '0;
      irq_level_r <= 1'b0;
    end else if (ce) begin
      irq_req_r   <= (hi_ok | lo_ok) & ~irq_ack & ~irq_return;
      irq_level_r <= hi_ok;
      irq_index_r <= hi_ok ? hi_idx : lo_idx;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hi_active_r <= 1'b0;
      lo_active_r <= 1'b0;
    end else if (ce) begin
      hi_active_r <= (svc_nxt == irq_prio_pkg::SVC_HIGH)
                   | (svc_nxt == irq_prio_pkg::SVC_HI_O_LO);
      lo_active_r <= (svc_nxt == irq_prio_pkg::SVC_LOW)
                   | (svc_nxt == irq_prio_pkg::SVC_HI_O_LO);
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  // Data stands one cycle after the strobe and returns to zero after
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= irq_prio_pkg::RDATA_IDLE;
    end else if (ce) begin
      rdata_r <= irq_prio_pkg::RDATA_IDLE;
      if (rd) begin
        case (addr)
          irq_prio_pkg::BASE_PRIO_ADDR: rdata_r <= base_prio_r;
          irq_prio_pkg::EXT_MASK_ADDR:  rdata_r <= ext_mask_r;
          irq_prio_pkg::EXT_PRIO_ADDR:  rdata_r <= ext_prio_r;
          irq_prio_pkg::STATUS_ADDR: begin
            rdata_r <= {hold_r, in_hi, in_lo, irq_req_r, irq_index_r};
          end
          default: rdata_r <= irq_prio_pkg::RDATA_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_base_top_one: assert property (
    @(posedge clock) disable iff (!rst_n)
    (ce && rd && addr == irq_prio_pkg::BASE_PRIO_ADDR) |=> rdata_r[7])
    else $error("base priority top bit read as zero");

  chk_ext_rsvd_zero: assert property (
    @(posedge clock) disable iff (!rst_n)
    (ce && rd && addr == irq_prio_pkg::EXT_MASK_ADDR)
    |=> !rdata_r[irq_prio_pkg::EXT_RSVD_BIT])
    else $error("reserved extended bit read as one");

  chk_ext_prio_store: assert property (
    @(posedge clock) disable iff (!rst_n)
    (ce && wr && addr == irq_prio_pkg::EXT_PRIO_ADDR)
    |=> ext_prio_r == ($past(wdata) & irq_prio_pkg::EXT_WMSK))
    else $error("extended priority write not stored");

  chk_global_block: assert property (
    @(posedge clock) disable iff (!rst_n)
    (ce && !global_irq_enable) |=> !irq_req_r)
    else $error("request raised with global enable off");

  chk_return_hold: assert property (
    @(posedge clock) disable iff (!rst_n)
    (ce && irq_return) ##1 (ce && !instr_done)[*2] |=> !irq_req_r)
    else $error("request before instruction after return");

  chk_low_no_preempt: assert property (
    @(posedge clock) disable iff (!rst_n)
    irq_req_r && (hi_active_r || lo_active_r) |-> irq_level_r && !hi_active_r)
    else $error("request would preempt equal or higher level");

  chk_high_first: assert property (
    @(posedge clock) disable iff (!rst_n)
    (ce && hi_ok && !irq_ack && !irq_return)
    |=> irq_req_r && irq_level_r && irq_index_r == $past(hi_idx))
    else $error("enabled high request not presented next cycle");

  chk_lowest_index: assert property (
    @(posedge clock) disable iff (!rst_n)
    hi_any |-> (hi_vec & ~({irq_prio_pkg::NUM_SRC{1'b1}} << hi_idx)) == '0)
    else $error("higher order number chosen over lower");

  chk_pca_mask: assert property (
    @(posedge clock) disable iff (!rst_n)
    !ext_mask_r[irq_prio_pkg::EXT_PCA_BIT]
    |-> !hi_vec[irq_prio_pkg::SRC_PCA] && !lo_vec[irq_prio_pkg::SRC_PCA])
    else $error("counter array passed while masked");

endmodule : interrupt_priority_enable
`default_nettype wire

// ===== cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Core side stand-in
// ----------------------------------------------------------------
module cpu_model (
  // Commands from the bench
  input  wire logic take,
  input  wire logic ret,
  input  wire logic step,
  // Request seen from the block
  input  wire logic irq_req_r,
  // Handshake to the block
  output logic      irq_ack,
  output logic      irq_return,
  output logic      instr_done
);
  // A real core only calls a vector that is presented to it
  assign irq_ack    = take & irq_req_r;
  assign irq_return = ret;
  assign instr_done = step;
endmodule : cpu_model
`default_nettype wire

// ===== test_interrupt_priority_enable.sv
`timescale 1ns/1ps
`default_nettype none
module test_interrupt_priority_enable;
  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  logic        clock    = 1'b0;
  logic        rst_n    = 1'b0;
  logic        ce       = 1'b1;
  logic [7:0]  addr     = 8'h00;
  logic [7:0]  wdata    = 8'h00;
  logic        wr       = 1'b0;
  logic        rd       = 1'b0;
  logic        gie      = 1'b1;
  logic [6:0]  base_en  = 7'h00;
  logic [14:0] pend     = 15'h0000;
  logic        alt      = 1'b0;
  logic        take     = 1'b0;
  logic        ret      = 1'b0;
  logic        step     = 1'b0;
  logic [7:0]  rdata_r;
  logic        irq_ack;
  logic        irq_return;
  logic        instr_done;
  logic        irq_req_r;
  logic [3:0]  irq_index_r;
  logic        irq_level_r;
  logic        hi_active_r;
  logic        lo_active_r;
  logic [7:0]  pv;
  int          err_total = 0;
  int          checks    = 0;

  // Half period of 2 ns gives 250 MHz
  always #2 clock = ~clock;

  // Paired flags: alt picks which of the two pends the source
  interrupt_priority_enable dut (
    .clock(clock), .rst_n(rst_n), .ce(ce),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata_r(rdata_r),
    .global_irq_enable(gie), .base_irq_enable(base_en),
    .ext_irq0_flag(pend[0]), .timer0_flag(pend[1]),
    .ext_irq1_flag(pend[2]), .timer1_flag(pend[3]),
    .serial_port_flags({pend[4] & alt, pend[4] & ~alt}),
    .timer2_flags({pend[5] & alt, pend[5] & ~alt}),
    .spi_flag(pend[6]), .smbus_flag(pend[7]),
    .adc_window_flag(pend[9]), .adc_done_flag(pend[10]),
    .counter_array_flag(pend[11]),
    .comparator0_rise_flag(pend[12] & alt),
    .comparator0_fall_flag(pend[12] & ~alt),
    .comparator1_rise_flag(pend[13] & alt),
    .comparator1_fall_flag(pend[13] & ~alt),
    .timer3_low_overflow_flag(pend[14] & ~alt),
    .timer3_high_overflow_flag(pend[14] & alt),
    .irq_ack(irq_ack), .irq_return(irq_return), .instr_done(instr_done),
    .irq_req_r(irq_req_r), .irq_index_r(irq_index_r),
    .irq_level_r(irq_level_r), .hi_active_r(hi_active_r),
    .lo_active_r(lo_active_r)
  );

  cpu_model core_side (
    .take(take), .ret(ret), .step(step), .irq_req_r(irq_req_r),
    .irq_ack(irq_ack), .irq_return(irq_return), .instr_done(instr_done)
  );

  // ----------------------------------------------------------------
  // Reporting
  // ----------------------------------------------------------------
  task automatic stop_test;
    $display("Mismatches %0d, comparisons %0d", err_total, checks);
    if (err_total == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : stop_test

  task automatic fail(input string msg);
    err_total++;
    $display("CHECK FAILED at %0t: %s", $time, msg);
  endtask : fail

  // ----------------------------------------------------------------
  // Register port and core handshake
  // ----------------------------------------------------------------
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clock);
    wr <= 1'b0;
  endtask : reg_wr

  // Read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd <= 1'b0;
    @(negedge clock);
    checks++;
    if (rdata_r !== exp) fail("register read value");
  endtask : reg_rd

  task automatic core(input logic [2:0] c);
    @(posedge clock);
    {take, ret, step} <= c;
    @(posedge clock);
    {take, ret, step} <= 3'b000;
  endtask : core

  task automatic chk_irq(input logic r, input logic [3:0] i, input logic l);
    @(negedge clock);
    checks++;
    if (irq_req_r !== r) fail("request line");
    else if (r && (irq_index_r !== i || irq_level_r !== l))
      fail("request index or level");
    // Return on a rising edge so the caller drives inputs there
    @(posedge clock);
  endtask : chk_irq

  task automatic chk_act(input logic h, input logic l);
    @(negedge clock);
    checks++;
    if (hi_active_r !== h || lo_active_r !== l) fail("service level");
    @(posedge clock);
  endtask : chk_act

  task automatic idle(input int n);
    repeat (n) @(posedge clock);
  endtask : idle

  // Bounded wait, a hang counts as a mismatch
  task automatic wait_req;
    int n;
    n = 0;
    // Always look at a settled value, never at the launching edge
    do begin
      @(negedge clock);
      n++;
    end while (irq_req_r !== 1'b1 && n < 10);
    if (irq_req_r !== 1'b1) begin
      fail("request never raised");
      stop_test();
    end
  endtask : wait_req

  initial begin
    #100000;
    fail("run time limit");
    stop_test();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    idle(5);
    rst_n <= 1'b1;
    reg_rd(8'hb8, 8'h80);
    reg_rd(8'he6, 8'h00);
    reg_rd(8'hf6, 8'h00);
    reg_wr(8'hb8, 8'h7f);
    reg_rd(8'hb8, 8'hff);
    reg_wr(8'hb8, 8'h00);
    reg_rd(8'hb8, 8'h80);
    reg_wr(8'he6, 8'hfd);
    reg_rd(8'he6, 8'hfd);
    reg_wr(8'hf6, 8'hff);
    // Clock enable low freezes the registers: this write must not land
    ce <= 1'b0;
    reg_wr(8'hf6, 8'h00);
    ce <= 1'b1;
    reg_rd(8'hf6, 8'hfd);
    reg_rd(8'h00, 8'h00);
    reg_wr(8'he6, 8'h00);
    // Every source but reserved source 8: blocked by its mask, then passed at its level
    for (int s = 0; s < 15; s++) begin
      if (s == 8) continue;
      pv  = 8'h01 << ((s < 7) ? s : ((s == 7) ? 0 : s - 7));
      alt <= s[1];
      reg_wr((s < 7) ? 8'hb8 : 8'hf6, s[0] ? pv : 8'h00);
      pend[s] <= 1'b1;
      idle(3);
      chk_irq(1'b0, 4'h0, 1'b0);
      if (s < 7) base_en <= pv[6:0];
      else reg_wr(8'he6, pv);
      wait_req();
      chk_irq(1'b1, 4'(s), s[0]);
      // The other flag of a paired source must hold the request alone
      alt <= ~alt;
      idle(2);
      chk_irq(1'b1, 4'(s), s[0]);
      gie <= 1'b0;
      idle(2);
      chk_irq(1'b0, 4'h0, 1'b0);
      gie     <= 1'b1;
      pend    <= 15'h0000;
      base_en <= 7'h00;
      reg_wr(8'he6, 8'h00);
      reg_wr((s < 7) ? 8'hb8 : 8'hf6, 8'h00);
      idle(2);
    end
    // Same level tie, then level change, then nesting
    base_en <= 7'h28;
    pend    <= 15'h0028;
    wait_req();
    chk_irq(1'b1, 4'h3, 1'b0);
    reg_wr(8'hb8, 8'h20);
    idle(2);
    chk_irq(1'b1, 4'h5, 1'b1);
    reg_wr(8'hb8, 8'h00);
    idle(2);
    core(3'b100);
    chk_irq(1'b0, 4'h0, 1'b0);
    chk_act(1'b0, 1'b1);
    // Status: low in service, no request, timer 1 still selected
    reg_rd(8'hf7, 8'h23);
    reg_wr(8'hb8, 8'h20);
    wait_req();
    chk_irq(1'b1, 4'h5, 1'b1);
    core(3'b100);
    pend[5] <= 1'b0;
    idle(3);
    chk_irq(1'b0, 4'h0, 1'b0);
    chk_act(1'b1, 1'b1);
    core(3'b010);
    core(3'b001);
    idle(3);
    chk_irq(1'b0, 4'h0, 1'b0);
    core(3'b010);
    idle(3);
    chk_irq(1'b0, 4'h0, 1'b0);
    chk_act(1'b0, 1'b0);
    core(3'b001);
    wait_req();
    chk_irq(1'b1, 4'h3, 1'b0);
    stop_test();
  end
endmodule : test_interrupt_priority_enable
`default_nettype wire
